// [hw/ast_tx.sv]
// Transmit path of the serial port: registers, baud divider, buffer and shifter.
`timescale 1ns/1ns
module ast_tx (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [ast_pkg::ADDR_W-1:0] addr_i,
	input wire logic [ast_pkg::DATA_W-1:0] wr_data_i,
	input wire logic wr_stb_i,
	input wire logic rd_stb_i,
	output logic [ast_pkg::DATA_W-1:0] rd_data_o,
	output logic tx_o,
	output logic irq_o
);
	// ****************************************************************
	// Software-visible state
	// ****************************************************************
	logic ninth_data_bit;
	logic baud_high_speed_select;
	logic sync_select;
	logic transmit_enable_control;
	logic nine_bit_select;
	logic serial_port_enable;
	logic transmit_polarity_invert;
	logic baud_wide_divisor_select;
	logic transmit_interrupt_enable;
	logic peripheral_irq_enable;
	logic global_irq_enable;
	logic [7:0] baud_divisor_low;
	logic [7:0] baud_divisor_high;
	logic shift_register_empty_flag;
	logic transmit_buffer_flag;

	// ****************************************************************
	// Shifter and baud state
	// ****************************************************************
	ast_pkg::ast_state_e state;
	ast_pkg::ast_state_e next_state;
	logic [ast_pkg::CHAR_W-1:0] transmit_shift_register;
	logic [3:0] bits_left;
	logic [15:0] baud_cnt;
	logic [5:0] phase_cnt;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire sel_status = (addr_i == ast_pkg::OFF_STATUS_CTRL);
	wire sel_hold = (addr_i == ast_pkg::OFF_HOLD_BUF);
	wire sel_blow = (addr_i == ast_pkg::OFF_BAUD_LOW);
	wire sel_bhigh = (addr_i == ast_pkg::OFF_BAUD_HIGH);
	wire sel_port = (addr_i == ast_pkg::OFF_PORT_CTRL);
	wire sel_irq = (addr_i == ast_pkg::OFF_IRQ_CTRL);
	wire wr_status = wr_stb_i && sel_status;
	wire wr_hold = wr_stb_i && sel_hold;
	wire wr_port = wr_stb_i && sel_port;
	wire wr_irq = wr_stb_i && sel_irq;

	// ****************************************************************
	// Mode and buffer wiring
	// ****************************************************************
	wire async_mode = serial_port_enable && !sync_select;
	wire tx_active = async_mode && transmit_enable_control;
	wire pol_eff = async_mode && transmit_polarity_invert;
	wire buf_in_ready;
	wire buf_out_valid;
	wire [ast_pkg::CHAR_W-1:0] buf_out_data;
	// The ninth bit is sampled at the holding write, so it must already be set.
	wire [ast_pkg::CHAR_W-1:0] buf_in_data = {ninth_data_bit, wr_data_i};
	wire load = tx_active && buf_out_valid && (state == ast_pkg::st_idle);

	ast_buf2 #(
		.WIDTH(ast_pkg::CHAR_W)
	) u_buf (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.flush_i(!tx_active),
		.in_valid_i(wr_hold),
		.in_ready_o(buf_in_ready),
		.in_data_i(buf_in_data),
		.out_valid_o(buf_out_valid),
		.out_ready_i(load),
		.out_data_o(buf_out_data)
	);

	// ****************************************************************
	// Baud divider
	// ****************************************************************
	wire [15:0] divisor = baud_wide_divisor_select ? {baud_divisor_high, baud_divisor_low}
		: {8'h00, baud_divisor_low};
	wire [1:0] speed_sel = {baud_wide_divisor_select, baud_high_speed_select};
	wire [5:0] phase_last = (speed_sel == 2'h3) ? ast_pkg::PHASE_LAST_WIDE_FAST
		: (speed_sel == 2'h0) ? ast_pkg::PHASE_LAST_SLOW : ast_pkg::PHASE_LAST_FAST;
	wire baud_tick = (baud_cnt == 16'h0000);
	wire bit_en = baud_tick && (phase_cnt == phase_last);

	// Restarting the divider at each load keeps the start bit a full bit long.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || load || !tx_active) begin
			baud_cnt <= divisor;
			phase_cnt <= 6'h00;
		end else if (baud_tick) begin
			baud_cnt <= divisor;
			phase_cnt <= bit_en ? 6'h00 : phase_cnt + 6'h01;
		end else begin
			baud_cnt <= baud_cnt - 16'h0001;
		end
	end

	// ****************************************************************
	// Shifter
	// ****************************************************************
	always_comb begin
		next_state = state;
		case (state)
			ast_pkg::st_idle: begin
				if (load) begin
					next_state = ast_pkg::st_start;
				end
			end
			ast_pkg::st_start: begin
				if (bit_en) begin
					next_state = ast_pkg::st_data;
				end
			end
			ast_pkg::st_data: begin
				if (bit_en && (bits_left == 4'h1)) begin
					next_state = ast_pkg::st_stop;
				end
			end
			ast_pkg::st_stop: begin
				if (bit_en) begin
					next_state = ast_pkg::st_idle;
				end
			end
			default: begin
				next_state = ast_pkg::st_idle;
			end
		endcase
		if (!tx_active) begin
			next_state = ast_pkg::st_idle;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state <= ast_pkg::st_idle;
			shift_register_empty_flag <= 1'b1;
		end else begin
			state <= next_state;
			shift_register_empty_flag <= (next_state == ast_pkg::st_idle);
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			transmit_shift_register <= {ast_pkg::CHAR_W{1'b0}};
			bits_left <= 4'h0;
		end else if (load) begin
			transmit_shift_register <= buf_out_data;
			bits_left <= nine_bit_select ? ast_pkg::BITS_NINE : ast_pkg::BITS_EIGHT;
		end else if (bit_en && (state == ast_pkg::st_data)) begin
			transmit_shift_register <= {1'b0, transmit_shift_register[ast_pkg::CHAR_W-1:1]};
			bits_left <= bits_left - 4'h1;
		end
	end

	// ****************************************************************
	// Line and interrupt outputs
	// ****************************************************************
	wire line = (state == ast_pkg::st_start) ? 1'b0
		: (state == ast_pkg::st_data) ? transmit_shift_register[0] : 1'b1;
	wire irq_req = transmit_buffer_flag && transmit_interrupt_enable
		&& peripheral_irq_enable && global_irq_enable;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			tx_o <= 1'b1;
			irq_o <= 1'b0;
			transmit_buffer_flag <= 1'b1;
		end else begin
			tx_o <= line ^ pol_eff;
			irq_o <= irq_req;
			transmit_buffer_flag <= buf_in_ready || !tx_active;
		end
	end

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// The empty flag has no write path; a status write leaves it alone.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ninth_data_bit <= 1'b0;
			baud_high_speed_select <= 1'b0;
			sync_select <= 1'b0;
			transmit_enable_control <= 1'b0;
			nine_bit_select <= 1'b0;
		end else if (wr_status) begin
			ninth_data_bit <= wr_data_i[ast_pkg::BIT_NINTH_DATA];
			baud_high_speed_select <= wr_data_i[ast_pkg::BIT_HIGH_SPEED];
			sync_select <= wr_data_i[ast_pkg::BIT_SYNC_SELECT];
			transmit_enable_control <= wr_data_i[ast_pkg::BIT_TX_ENABLE];
			nine_bit_select <= wr_data_i[ast_pkg::BIT_NINE_SELECT];
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			baud_divisor_low <= ast_pkg::RST_BYTE;
			baud_divisor_high <= ast_pkg::RST_BYTE;
		end else if (wr_stb_i) begin
			baud_divisor_low <= sel_blow ? wr_data_i : baud_divisor_low;
			baud_divisor_high <= sel_bhigh ? wr_data_i : baud_divisor_high;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			serial_port_enable <= 1'b0;
			transmit_polarity_invert <= 1'b0;
			baud_wide_divisor_select <= 1'b0;
			transmit_interrupt_enable <= 1'b0;
			peripheral_irq_enable <= 1'b0;
			global_irq_enable <= 1'b0;
		end else begin
			if (wr_port) begin
				serial_port_enable <= wr_data_i[ast_pkg::BIT_PORT_ENABLE];
				transmit_polarity_invert <= wr_data_i[ast_pkg::BIT_POL_INVERT];
				baud_wide_divisor_select <= wr_data_i[ast_pkg::BIT_WIDE_DIV];
			end
			if (wr_irq) begin
				transmit_interrupt_enable <= wr_data_i[ast_pkg::BIT_TX_IRQ_EN];
				peripheral_irq_enable <= wr_data_i[ast_pkg::BIT_PERIPH_IRQ_EN];
				global_irq_enable <= wr_data_i[ast_pkg::BIT_GLOBAL_IRQ_EN];
			end
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	wire [7:0] status_rd = {1'b0, nine_bit_select, transmit_enable_control, sync_select,
		1'b0, baud_high_speed_select, shift_register_empty_flag, ninth_data_bit};
	wire [7:0] port_rd = {5'h00, baud_wide_divisor_select, transmit_polarity_invert,
		serial_port_enable};
	wire [7:0] irq_rd = {4'h0, transmit_buffer_flag, global_irq_enable,
		peripheral_irq_enable, transmit_interrupt_enable};
	// The holding buffer reads as zero so the shifter contents never leak out.
	wire [7:0] rd_mux = sel_status ? status_rd : sel_blow ? baud_divisor_low
		: sel_bhigh ? baud_divisor_high : sel_port ? port_rd
		: sel_irq ? irq_rd : 8'h00;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rd_data_o <= ast_pkg::RST_BYTE;
		end else begin
			rd_data_o <= rd_stb_i ? rd_mux : 8'h00;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_empty_idle;
		@(posedge clock_i) disable iff (sys_rst_i)
		shift_register_empty_flag == (state == ast_pkg::st_idle);
	endproperty
	a_empty_idle: assert property (p_empty_idle) else $error("empty flag mismatch");

	property p_load_clears;
		@(posedge clock_i) disable iff (sys_rst_i)
		load |=> !shift_register_empty_flag;
	endproperty
	a_load_clears: assert property (p_load_clears) else $error("flag not cleared");

	property p_busy_data;
		@(posedge clock_i) disable iff (sys_rst_i)
		(state == ast_pkg::st_data && tx_active) |=> !shift_register_empty_flag;
	endproperty
	a_busy_data: assert property (p_busy_data) else $error("flag set mid frame");

	property p_nine_count;
		@(posedge clock_i) disable iff (sys_rst_i)
		(load && nine_bit_select) |=> (bits_left == 4'h9) && (state == ast_pkg::st_start);
	endproperty
	a_nine_count: assert property (p_nine_count) else $error("bad bit count");

	property p_ninth_msb;
		@(posedge clock_i) disable iff (sys_rst_i)
		load |=> transmit_shift_register[8] == $past(buf_out_data[8]);
	endproperty
	a_ninth_msb: assert property (p_ninth_msb) else $error("ninth bit lost");

	property p_load_prompt;
		@(posedge clock_i) disable iff (sys_rst_i)
		(wr_hold && buf_in_ready && tx_active && state == ast_pkg::st_idle && !buf_out_valid)
		##1 tx_active |-> load;
	endproperty
	a_load_prompt: assert property (p_load_prompt) else $error("load delayed");

	property p_disabled_idle;
		@(posedge clock_i) disable iff (sys_rst_i)
		!tx_active |=> state == ast_pkg::st_idle;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("ran while off");

	property p_invert;
		@(posedge clock_i) disable iff (sys_rst_i)
		(pol_eff && state == ast_pkg::st_idle) |=> !tx_o;
	endproperty
	a_invert: assert property (p_invert) else $error("idle not inverted");

	property p_start_low;
		@(posedge clock_i) disable iff (sys_rst_i)
		(state == ast_pkg::st_start && !pol_eff) |=> !tx_o;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");

	property p_enable_flag;
		@(posedge clock_i) disable iff (sys_rst_i)
		$rose(tx_active) |=> transmit_buffer_flag;
	endproperty
	a_enable_flag: assert property (p_enable_flag) else $error("flag not set");

	property p_irq;
		@(posedge clock_i) disable iff (sys_rst_i)
		irq_req |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule : ast_tx

// [hw/ast_pkg.sv]
// Constants, register map and state encoding of the asynchronous serial transmitter.
package ast_pkg;
	// ****************************************************************
	// Bus geometry
	// ****************************************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int CHAR_W = 9;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [3:0] OFF_STATUS_CTRL = 4'h0;
	localparam logic [3:0] OFF_HOLD_BUF = 4'h1;
	localparam logic [3:0] OFF_BAUD_LOW = 4'h2;
	localparam logic [3:0] OFF_BAUD_HIGH = 4'h3;
	localparam logic [3:0] OFF_PORT_CTRL = 4'h4;
	localparam logic [3:0] OFF_IRQ_CTRL = 4'h5;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BIT_NINTH_DATA = 0;
	localparam int BIT_SR_EMPTY = 1;
	localparam int BIT_HIGH_SPEED = 2;
	localparam int BIT_SYNC_SELECT = 4;
	localparam int BIT_TX_ENABLE = 5;
	localparam int BIT_NINE_SELECT = 6;
	localparam int BIT_PORT_ENABLE = 0;
	localparam int BIT_POL_INVERT = 1;
	localparam int BIT_WIDE_DIV = 2;
	localparam int BIT_TX_IRQ_EN = 0;
	localparam int BIT_PERIPH_IRQ_EN = 1;
	localparam int BIT_GLOBAL_IRQ_EN = 2;
	localparam int BIT_TX_BUF_FLAG = 3;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;

	// ****************************************************************
	// Timing: last phase count (baud ticks per bit minus one) for each speed selection, and data bits per character
	// ****************************************************************
	localparam logic [5:0] PHASE_LAST_SLOW = 6'h3F;
	localparam logic [5:0] PHASE_LAST_FAST = 6'h0F;
	localparam logic [5:0] PHASE_LAST_WIDE_FAST = 6'h03;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;

	// ****************************************************************
	// Shifter states
	// ****************************************************************
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_start = 2'b01,
		st_data = 2'b11,
		st_stop = 2'b10
	} ast_state_e;
endpackage : ast_pkg

// [hw/ast_buf2.sv]
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ns
module ast_buf2 #(
	parameter int WIDTH = 9
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [WIDTH-1:0] mem [0:1];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;

	assign in_ready_o = (count != 2'h2);
	assign out_valid_o = (count != 2'h0);
	assign out_data_o = mem[rd_ptr];

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// A flush empties both entries; pending words are dropped on purpose.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || flush_i) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			wr_ptr <= wr_ptr ^ push;
			rd_ptr <= rd_ptr ^ pop;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : ast_buf2

// [tb/ast_rx_model.sv]
// Behavioural model of the remote asynchronous receiver that listens on the transmit line.
`timescale 1ns/1ns
module ast_rx_model #(
	parameter int BIT_CLKS = 4
) (
	input wire logic clock_i,
	input wire logic rx_i,
	input wire logic invert_i,
	input wire logic nine_i,
	output logic got_o,
	output logic [8:0] char_o,
	output logic stop_o,
	output logic addr_o
);
	logic line;
	logic busy = 1'b0;
	logic [8:0] sh = 9'h000;
	int t = 0;
	int k;

	// The receiver is told the polarity; a wrong guess shows up as a wrong character.
	assign line = rx_i ^ invert_i;

	initial begin
		got_o = 1'b0;
		char_o = 9'h000;
		stop_o = 1'b0;
		addr_o = 1'b0;
	end

	// Sampling sits in the middle of each bit, so a one-cycle glitch is not taken as a start.
	always @(posedge clock_i) begin
		got_o <= 1'b0;
		if (!busy) begin
			t <= 2;
			busy <= (line === 1'b0);
		end else begin
			t <= t + 1;
			if (t % BIT_CLKS == BIT_CLKS / 2) begin
				k = t / BIT_CLKS;
				if (k == 0) begin
					busy <= (line === 1'b0);
				end else if (k <= (nine_i ? 9 : 8)) begin
					sh[k-1] = line;
				end else begin
					char_o <= nine_i ? sh : {1'b0, sh[7:0]};
					addr_o <= nine_i & sh[8];
					stop_o <= line;
					got_o <= 1'b1;
					busy <= 1'b0;
				end
			end
		end
	end
endmodule : ast_rx_model

// [tb/async_serial_transmitter_bench.sv]
// Self-checking testbench of the asynchronous serial transmitter.
`timescale 1ns/1ns
module async_serial_transmitter_bench;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wr_data = 8'h00;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [7:0] rd_data;
	logic tx;
	logic irq;
	logic got;
	logic stop;
	logic is_addr;
	logic [8:0] rx_char;
	logic inv = 1'b0;
	logic nine = 1'b0;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;
	int n_rx = 0;

	always #5 clock_i = ~clock_i;

	// Divisor 0 with both speed selects gives four clocks per bit.
	ast_tx dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wr_data_i(wr_data),
		.wr_stb_i(wr_stb), .rd_stb_i(rd_stb), .rd_data_o(rd_data), .tx_o(tx), .irq_o(irq));
	ast_rx_model #(.BIT_CLKS(4)) rx_u (.clock_i(clock_i), .rx_i(tx), .invert_i(inv),
		.nine_i(nine), .got_o(got), .char_o(rx_char), .stop_o(stop), .addr_o(is_addr));

	always @(posedge clock_i) begin
		if (got === 1'b1) begin
			n_rx++;
		end
	end

	// ****************************************************************
	// Access and compare tasks
	// ****************************************************************
	task automatic chk(input logic [8:0] got_v, input logic [8:0] exp_v);
		num_checks++;
		if (got_v !== exp_v) begin
			fails++;
			$display("ERROR at %0t ns: got %h expected %h", $time, got_v, exp_v);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clock_i);
		addr <= a;
		wr_data <= v;
		wr_stb <= 1'b1;
		@(posedge clock_i);
		wr_stb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clock_i);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock_i);
		rd_stb <= 1'b0;
		#1;
		v = rd_data;
	endtask : rd

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp_v);
		logic [7:0] v;
		rd(a, v);
		chk({1'b0, v}, {1'b0, exp_v});
	endtask : rd_chk

	task automatic pin_chk(input logic pin, input logic exp_v);
		chk({8'h00, pin}, {8'h00, exp_v});
	endtask : pin_chk

	// Polling keeps this independent of the exact cycle the stop bit ends.
	task automatic wait_empty();
		logic [7:0] v;
		for (int i = 0; i < 30; i++) begin
			rd(ast_pkg::OFF_STATUS_CTRL, v);
			if (v[ast_pkg::BIT_SR_EMPTY] === 1'b1) break;
		end
		pin_chk(v[ast_pkg::BIT_SR_EMPTY], 1'b1);
	endtask : wait_empty

	task automatic expect_char(input logic [8:0] exp_v);
		int n;
		n = 0;
		while (got !== 1'b1 && n < 200) begin
			@(posedge clock_i);
			#1;
			n++;
		end
		chk(rx_char, exp_v);
		pin_chk(stop, 1'b1);
		@(posedge clock_i);
		#1;
	endtask : expect_char

	task automatic final_report();
		$display("Comparisons: %0d, mismatches: %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	// The whole sequence needs well under a thousand cycles; this ceiling only cuts a hang.
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			final_report();
		end
	end

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		repeat (16) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		rd_chk(ast_pkg::OFF_STATUS_CTRL, 8'h02);
		// Read data stand for one cycle only and fall back to zero after it.
		@(posedge clock_i);
		#1;
		chk({1'b0, rd_data}, 9'h000);
		rd_chk(ast_pkg::OFF_IRQ_CTRL, 8'h08);
		rd_chk(ast_pkg::OFF_HOLD_BUF, 8'h00);
		rd_chk(4'hF, 8'h00);
		pin_chk(tx, 1'b1);
		pin_chk(irq, 1'b0);
		wr(ast_pkg::OFF_BAUD_LOW, 8'h00);
		wr(ast_pkg::OFF_BAUD_HIGH, 8'h00);
		wr(ast_pkg::OFF_PORT_CTRL, 8'h05);
		wr(ast_pkg::OFF_STATUS_CTRL, 8'h24);
		rd_chk(ast_pkg::OFF_STATUS_CTRL, 8'h26);
		wr(ast_pkg::OFF_IRQ_CTRL, 8'h07);
		rd_chk(ast_pkg::OFF_IRQ_CTRL, 8'h0F);
		pin_chk(irq, 1'b1);
		wr(ast_pkg::OFF_HOLD_BUF, 8'hA5);
		repeat (4) @(posedge clock_i);
		rd_chk(ast_pkg::OFF_STATUS_CTRL, 8'h24);
		repeat (10) @(posedge clock_i);
		rd_chk(ast_pkg::OFF_STATUS_CTRL, 8'h24);
		expect_char(9'h0A5);
		wait_empty();
		wr(ast_pkg::OFF_HOLD_BUF, 8'h01);
		wr(ast_pkg::OFF_HOLD_BUF, 8'h80);
		wr(ast_pkg::OFF_HOLD_BUF, 8'h3E);
		rd_chk(ast_pkg::OFF_IRQ_CTRL, 8'h07);
		pin_chk(irq, 1'b0);
		expect_char(9'h001);
		expect_char(9'h080);
		expect_char(9'h03E);
		wait_empty();
		rd_chk(ast_pkg::OFF_IRQ_CTRL, 8'h0F);
		nine <= 1'b1;
		wr(ast_pkg::OFF_STATUS_CTRL, 8'h65);
		wr(ast_pkg::OFF_HOLD_BUF, 8'h3C);
		expect_char(9'h13C);
		pin_chk(is_addr, 1'b1);
		wait_empty();
		wr(ast_pkg::OFF_STATUS_CTRL, 8'h64);
		wr(ast_pkg::OFF_HOLD_BUF, 8'hC3);
		expect_char(9'h0C3);
		pin_chk(is_addr, 1'b0);
		wait_empty();
		nine <= 1'b0;
		wr(ast_pkg::OFF_STATUS_CTRL, 8'h34);
		wr(ast_pkg::OFF_HOLD_BUF, 8'h77);
		repeat (80) @(posedge clock_i);
		// Six characters were sent so far; the one written while off must not appear.
		chk(n_rx[8:0], 9'h006);
		pin_chk(tx, 1'b1);
		rd_chk(ast_pkg::OFF_IRQ_CTRL, 8'h0F);
		wr(ast_pkg::OFF_STATUS_CTRL, 8'h24);
		wr(ast_pkg::OFF_PORT_CTRL, 8'h07);
		repeat (2) @(posedge clock_i);
		inv <= 1'b1;
		#1;
		pin_chk(tx, 1'b0);
		repeat (60) @(posedge clock_i);
		wr(ast_pkg::OFF_HOLD_BUF, 8'h5A);
		expect_char(9'h05A);
		wait_empty();
		wr(ast_pkg::OFF_HOLD_BUF, 8'h00);
		repeat (12) @(posedge clock_i);
		wr(ast_pkg::OFF_STATUS_CTRL, 8'h04);
		// The state drops to idle one edge after the write and the line follows one edge later.
		repeat (2) @(posedge clock_i);
		#1;
		pin_chk(tx, 1'b0);
		rd_chk(ast_pkg::OFF_STATUS_CTRL, 8'h06);
		final_report();
	end
endmodule : async_serial_transmitter_bench
